// ---- hdl/sram_array.sv ----
`default_nettype none
`include "sram_cycle_params.svh"
module sram_array
   import sram_cycle_pkg::*;
#(
   parameter int ADDR_W = `ADDR_WIDTH,
   parameter int LANE_W = `LANE_WIDTH,
   parameter int LANES  = `LANE_COUNT
) (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic                    writeEn,
   input  wire logic [ADDR_W-1:0]       writeAddr,
   input  wire logic [LANES-1:0]        writeMask,
   input  wire logic [LANES*LANE_W-1:0] writeData,
   input  wire logic                    fwdEn,
   input  wire logic [ADDR_W-1:0]       fwdAddr,
   input  wire logic [LANES-1:0]        fwdMask,
   input  wire logic [LANES*LANE_W-1:0] fwdData,
   input  wire logic                    readEn,
   input  wire logic [ADDR_W-1:0]       readAddr,
   output logic      [LANES*LANE_W-1:0] readData
);
   localparam int DW = LANES * LANE_W;

   logic [DW-1:0] store [0:(2**ADDR_W)-1]; // Storage cells
   logic [DW-1:0] next_readData;           // Merged read word

   // Replace the masked lanes of a word
   function automatic logic [DW-1:0] mergeLanes(
      input logic [DW-1:0]    oldWord,
      input logic [DW-1:0]    newWord,
      input logic [LANES-1:0] mask);
      logic [DW-1:0] w;
      w = oldWord;
      for (int i = 0; i < LANES; i++) begin
         if (mask[i]) begin
            w[i*LANE_W +: LANE_W] = newWord[i*LANE_W +: LANE_W];
         end
      end
      return w;
   endfunction

   // Lane-gated write
   always_ff @(posedge clk) begin
      if (writeEn) begin
         store[writeAddr] <= mergeLanes(store[writeAddr], writeData,
                                        writeMask);
      end
   end

   // Read sees the older write, then the newer forwarded one
   always_comb begin
      next_readData = store[readAddr];
      if (writeEn && writeAddr == readAddr) begin
         next_readData = mergeLanes(next_readData, writeData, writeMask);
      end
      if (fwdEn && fwdAddr == readAddr) begin
         next_readData = mergeLanes(next_readData, fwdData, fwdMask);
      end
   end

   // Read register holds when no read is issued
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readData <= '0;
      end else if (readEn) begin
         readData <= next_readData;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/sram_cycle_params.svh ----
`ifndef SRAM_CYCLE_PARAMS_SVH
`define SRAM_CYCLE_PARAMS_SVH
// Array geometry defaults
`define ADDR_WIDTH  17
`define LANE_WIDTH  9
`define LANE_COUNT  4
// Burst counter width and its reset value
`define BURST_BITS  2
`define COUNT_RESET 2'h0
// Write buffer depth in entries
`define BUF_DEPTH   2
// Output drivers are off out of reset
`define OE_RESET    1'b0
`endif

// ---- hdl/sram_cycle_pkg.sv ----
`default_nettype none
package sram_cycle_pkg;
`include "sram_cycle_params.svh"

   // Cycle state, one-hot
   typedef enum logic [2:0] {
      ST_DESELECT = 3'b001,
      ST_READ     = 3'b010,
      ST_WRITE    = 3'b100
   } cycle_state_e;

   // Burst position within a four-beat group
   typedef logic [`BURST_BITS-1:0] burst_t;

   // One bit per byte lane
   typedef logic [`LANE_COUNT-1:0] lane_mask_t;
endpackage
`default_nettype wire

// ---- hdl/sync_sram_cycle_control.sv ----
// Behaviour
// - State changes only on rising clock edge
// - Clock enable high freezes all state except the snooze drive-off
// - Read stall keeps data drivers on
// - Write stall keeps bus off, no write
// - Burst continue repeats the begin cycle type
// - Continue deselect only after a deselect
// - Dummy read and write abort: bus off
// - Write with no lanes changes nothing
// - Drivers off during writes, any enable level
// - Each byte enable gates its lane
// - All byte enables low writes whole word
// - Drivers off from power-up until a read
// - Two-bit burst counter wraps every four
// - Counter advances on every continue cycle
// - Unselected begin deselects, continues stay off
// - Load captures address, advance ignores direction
// - Chip selects sampled only on load
// - Order pin picks linear or interleaved
`default_nettype none
`include "sram_cycle_params.svh"

// Cycle control for a flow-through memory with late writes
// Only taken edges act: clock enable low and no snooze; snooze alone still turns the drivers off
// Reads: address edge, data registered right after it
// Writes: address and lanes first, data one taken edge later

// Inside, in order of the data flow:
//  - Pin decode into begin, continue and select terms
//  - Cycle register with the type of the running burst
//  - Burst counter and begin address for burst addresses
//  - Late-write bookkeeping for the owed data beat
//  - Two-entry queue between the data pins and the array
//  - Array with lane masks and read forwarding

// Read walk:
//  - Edge 0 takes the address, the read register loads
//  - After edge 0 the word and the driver enable stand
//  - Each continue edge loads the next burst word
// Write walk:
//  - Edge 0 takes address and lanes, drivers turn off
//  - Edge 1 takes the data word into the queue
//  - Edge 2 writes it into the array

// Reset:
//  - State deselect, count zero, drivers off, read word zero
//  - First command may come on the first edge after release
//  - Array contents are not cleared by reset

// Limits a user must know:
//  - Burst order pin is read live; keep it steady in a burst
//  - Output enable is sampled with the read, not asynchronous
//  - A stalled data edge defers the owed write, never drops it
//  - No turnaround cycles between reads and writes
module sync_sram_cycle_control
   import sram_cycle_pkg::*;
#(
   parameter int ADDR_W = `ADDR_WIDTH,
   parameter int LANE_W = `LANE_WIDTH,
   parameter int LANES  = `LANE_COUNT
) (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic [ADDR_W-1:0]       address,
   input  wire logic                    chipSelect_n,
   input  wire logic                    expansion_select_n,
   input  wire logic                    expansion_select,
   input  wire logic                    snooze_request,
   input  wire logic                    advance_or_load_n,
   input  wire logic                    readNotWrite,
   input  wire logic [LANES-1:0]        byte_write_enables_n,
   input  wire logic                    outputEnable_n,
   input  wire logic                    clockEnable_n,
   input  wire logic                    burstOrder,
   input  wire logic [LANES*LANE_W-1:0] dqIn,
   output logic      [LANES*LANE_W-1:0] dqOut,
   output logic                         dqOe
);
   // Word and buffer entry widths
   localparam int DW = LANES * LANE_W;
   localparam int BW = ADDR_W + LANES + DW;
   // Queue entry, high to low: address, lane mask, data word
   // Width of the burst field in the low address bits
   localparam int LB = `BURST_BITS;

   // Cycle tracking
   cycle_state_e state;       // Type of the running burst
   cycle_state_e next_state;  // Type after this edge
   burst_t       count;       // Beats since the begin cycle
   burst_t       next_count;  // Count after this edge
   logic [ADDR_W-1:0] base;   // Address of the begin cycle

   // Edge qualification
   logic clockOn;             // Edge not blocked by stall or snooze
   logic go;                  // Edge really taken
   logic isLoad;              // Begin cycle on this edge
   logic selected;            // All three selects active

   // Address generation
   logic [ADDR_W-1:0] baseNow;     // Base seen by this edge
   burst_t            lowNow;      // Low bits after ordering
   logic [ADDR_W-1:0] effAddr;     // Address used by this edge

   // Access issue
   logic readIssue;           // Array read on this edge
   logic writeIssue;          // Write address phase on this edge

   // Late write bookkeeping
   logic              pendValid; // Data due on next taken edge
   logic [ADDR_W-1:0] pendAddr;  // Where that data goes
   lane_mask_t        pendMask;  // Lanes to be written

   // Buffer handshakes
   logic          fillValid;  // Write data to be queued
   logic          fillReady;  // Buffer can take it
   logic [BW-1:0] fillData;   // Address, lanes and data
   logic          drainValid; // Queued write waiting
   logic          drainReady; // Array may take it now
   logic [BW-1:0] drainData;  // Head of the queue
   logic          memWrite;   // Array write strobe

   // Next burst low bits in the selected order
   // Linear wraps by the modulo-four add of two bits
   // Interleaved flips the start bits with the beat number
   // Both orders return to the start after four beats
   function automatic burst_t orderedLow(
      input burst_t start,
      input burst_t beat,
      input logic   interleave);
      burst_t r;
      if (interleave) begin
         r = start ^ beat;
      end else begin
         r = start + beat;
      end
      return r;
   endfunction

   // Edges are taken only when not stalled or snoozing
   // A blocked edge leaves every register of the block alone, except that snooze clears dqOe
   // Snooze outranks all other pins
   always_comb begin
      clockOn = !clockEnable_n && !snooze_request;
   end

   // A full buffer holds the edge like a wait state
   // Push and drain share taken edges, so it never fills
   // Kept as a guard: no owed write word may be lost
   always_comb begin
      go = clockOn && fillReady;
   end

   // Begin cycle and select decoding
   // Selects only count on begin cycles
   // Continue cycles ignore them and the direction pin
   // One inactive select is enough to deselect
   always_comb begin
      isLoad   = !advance_or_load_n;
      selected = !chipSelect_n && !expansion_select_n
                 && expansion_select;
   end

   // Count restarts on load and steps on continue
   // Two bits, so the fourth step wraps to the begin address
   // Steps in every continue: dummy reads, aborts, deselects
   always_comb begin
      if (isLoad) begin
         // Begin beat is count zero
         next_count = `COUNT_RESET;
      end else begin
         next_count = count + 1'b1;
      end
   end

   // Effective address for this edge
   // Load uses the pins, continue the stored begin address
   // Upper bits never change inside a burst
   always_comb begin
      baseNow = isLoad ? address : base;
      // Begin beat has count zero, so it is the pin address
      lowNow  = orderedLow(baseNow[LB-1:0], next_count, burstOrder);
      effAddr = {baseNow[ADDR_W-1:LB], lowNow};
   end

   // Cycle type after this edge
   // Every state decodes alike: load picks a new type
   // Continue keeps it, so a deselect stays a deselect
   // Reset state is deselect, so early continues stay off
   always_comb begin
      case (state)
         ST_DESELECT,
         ST_READ,
         ST_WRITE: begin
            if (isLoad) begin
               if (!selected) begin
                  next_state = ST_DESELECT;
               end else if (readNotWrite) begin
                  // Selected read begins a read burst
                  next_state = ST_READ;
               end else begin
                  // Selected write begins a write burst
                  next_state = ST_WRITE;
               end
            end else begin
               // Continue keeps the begin type
               next_state = state;
            end
         end
         // Illegal code falls back to deselect
         default: begin
            next_state = ST_DESELECT;
         end
      endcase
   end

   // Access strobes
   // Dummy reads still read the array; only drivers stay off
   // Write strobe opens the address phase of a late write
   always_comb begin
      readIssue  = go && (next_state == ST_READ);
      writeIssue = go && (next_state == ST_WRITE);
   end

   // Cycle state register
   // Moves only on taken rising edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_DESELECT;
      end else if (go) begin
         // Taken edge commits the decoded type
         state <= next_state;
      end
   end

   // Burst counter and base address
   // Base is captured only on load edges
   // Count advances even while deselected, unseen outside
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= `COUNT_RESET;
         base  <= '0;
      end else if (go) begin
         count <= next_count;
         if (isLoad) begin
            // Begin address kept for the whole burst
            base <= address;
         end
      end
   end

   // Late write: address phase now, data on the next taken edge
   // Owed flag clears on the data edge unless a new write follows
   // Stalled or snoozed edges keep the owed write waiting
   // Lane mask is kept active high from here on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pendValid <= 1'b0;
         pendAddr  <= '0;
         pendMask  <= '0;
      end else if (go) begin
         // Any new command decides whether a beat is owed
         pendValid <= writeIssue;
         pendAddr  <= effAddr;
         pendMask  <= ~byte_write_enables_n;
      end
   end

   // Data drivers
   // Off out of reset and until a real read
   // Stall keeps the level: on for reads, off for writes
   // Writes, deselects and dummy reads all end up off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dqOe <= `OE_RESET;
      end else if (snooze_request) begin
         // Snooze forces the drivers off at once
         dqOe <= 1'b0;
      end else if (go) begin
         // On only for a real read with the enable active
         dqOe <= readIssue && !outputEnable_n;
      end
   end

   // Queue the data only when some lane is enabled
   // An abort or empty mask owes a beat but writes nothing
   // Data pins are taken on the same edge as the next command
   always_comb begin
      fillValid = clockOn && pendValid && (pendMask != '0);
      // Entry layout matches the drain slices below
      fillData  = {pendAddr, pendMask, dqIn};
   end

   // The array drains on every edge not blocked by stall or snooze, taken or not
   // A stalled edge must not write, so the head waits
   always_comb begin
      drainReady = clockOn;
      // Head written on any edge not blocked by stall or snooze
      memWrite   = drainValid && drainReady;
   end

   // Two-entry queue between the pins and the array
   // Head drains on the edge after its push, so the second entry stays empty
   write_buffer #(
      .WIDTH (BW),
      .DEPTH (`BUF_DEPTH)
   ) u_write_buffer (
      .clk      (clk),
      .rstn     (rstn),
      .inValid  (fillValid),
      .inReady  (fillReady),
      .inData   (fillData),
      .outValid (drainValid),
      .outReady (drainReady),
      .outData  (drainData)
   );

   // Storage with lane masks and a registered read
   // Read forwarding keeps a read right after a write coherent
   // Read register is the data output, so it comes from a flop
   sram_array #(
      .ADDR_W (ADDR_W),
      .LANE_W (LANE_W),
      .LANES  (LANES)
   ) u_sram_array (
      .clk       (clk),
      .rstn      (rstn),
      .writeEn   (memWrite),
      .writeAddr (drainData[BW-1 -: ADDR_W]),
      .writeMask (drainData[DW +: LANES]),
      .writeData (drainData[DW-1:0]),
      .fwdEn     (fillValid && fillReady),
      .fwdAddr   (pendAddr),
      .fwdMask   (pendMask),
      .fwdData   (dqIn),
      .readEn    (readIssue),
      .readAddr  (effAddr),
      .readData  (dqOut)
   );
endmodule
`default_nettype wire

// ---- hdl/write_buffer.sv ----
`default_nettype none
`include "sram_cycle_params.svh"
module write_buffer
   import sram_cycle_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = `BUF_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] slot [0:DEPTH-1]; // Entries
   logic [PW-1:0]    wrPtr;            // Fill position
   logic [PW-1:0]    rdPtr;            // Drain position
   logic [PW:0]      used;             // Occupancy
   logic             push;             // Entry accepted
   logic             pop;              // Entry drained

   // Room while fewer than DEPTH entries are held
   assign inReady  = (used < (PW+1)'(DEPTH));
   assign outValid = (used != '0);
   assign outData  = slot[rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Entry storage
   always_ff @(posedge clk) begin
      if (push) begin
         slot[wrPtr] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         used  <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         if (push && !pop) begin
            used <= used + 1'b1;
         end else if (pop && !push) begin
            used <= used - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/sram_host_model.sv ----
`default_nettype none
module sram_host_model
   import sram_cycle_pkg::*;
(
   input  wire logic   clk,
   output logic [16:0] address,
   output logic        chipSelect_n,
   output logic        expansion_select_n,
   output logic        expansion_select,
   output logic        snooze_request,
   output logic        advance_or_load_n,
   output logic        readNotWrite,
   output logic [3:0]  byte_write_enables_n,
   output logic        outputEnable_n,
   output logic        clockEnable_n,
   output logic        burstOrder,
   output logic [35:0] dqIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       stall;  // Stall the next cycle
   logic       snooze; // Snooze the next cycle
   logic [2:0] sel;    // Selects, in port order
   logic       order;  // Burst order level
   // Idle pins at time zero
   initial begin
      stall = 1'b0;
      snooze = 1'b0;
      sel = 3'b001;
      order = 1'b1;
      {chipSelect_n, expansion_select_n, expansion_select} = 3'b110;
      {snooze_request, advance_or_load_n, readNotWrite} = 3'b000;
      {outputEnable_n, clockEnable_n, burstOrder} = 3'b001;
      byte_write_enables_n = 4'hF;
      address = '0;
      dqIn = '0;
   end
   // One cycle: pins move on the falling edge
   task automatic cmd(input logic ldn, rnw, input logic [3:0] be,
                      input logic oen, input logic [16:0] a,
                      input logic [35:0] d, input logic dv);
      @(negedge clk);
      clockEnable_n = stall;
      snooze_request = snooze;
      {chipSelect_n, expansion_select_n, expansion_select} = sel;
      burstOrder = order;
      advance_or_load_n = ldn;
      readNotWrite = rnw;
      byte_write_enables_n = be;
      outputEnable_n = oen;
      address = a;
      // Data only one cycle after its write, else a moving pattern
      dqIn = dv ? d : ~dqIn;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ---- verif/sync_sram_cycle_control_bench.sv ----
`default_nettype none
module sync_sram_cycle_control_bench
   import sram_cycle_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, cs_n, es_n, es, snz, ldn, rnw, oen, cken_n, ord, dqOe;
   logic [16:0] address;
   logic [3:0]  be_n;
   logic [35:0] dqIn, dqOut;
   logic [35:0] mem [0:63]; // Expected contents
   logic [35:0] nd;         // Late write data owed
   logic        nv;         // Data beat owed
   int          mismatches;
   int          testsRun;

   sync_sram_cycle_control i_dut (.clk(clk), .rstn(rstn), .address(address),
      .chipSelect_n(cs_n), .expansion_select_n(es_n), .expansion_select(es),
      .snooze_request(snz), .advance_or_load_n(ldn), .readNotWrite(rnw),
      .byte_write_enables_n(be_n), .outputEnable_n(oen),
      .clockEnable_n(cken_n), .burstOrder(ord), .dqIn(dqIn), .dqOut(dqOut),
      .dqOe(dqOe));
   sram_host_model i_host (.clk(clk), .address(address),
      .chipSelect_n(cs_n), .expansion_select_n(es_n), .expansion_select(es),
      .snooze_request(snz), .advance_or_load_n(ldn), .readNotWrite(rnw),
      .byte_write_enables_n(be_n), .outputEnable_n(oen),
      .clockEnable_n(cken_n), .burstOrder(ord), .dqIn(dqIn));

   task automatic chk(input string what, input logic [35:0] seen, exp);
      testsRun++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One cycle; owed data goes out on the next taken edge
   task automatic op(input logic l, r, input logic [3:0] b, input logic o,
                     input logic [16:0] a);
      logic tk;
      tk = !i_host.stall && !i_host.snooze;
      i_host.cmd(l, r, b, o, a, nd, nv && tk);
      if (tk) nv = 1'b0;
   endtask
   task automatic put(input logic [5:0] a, input logic [3:0] b,
                      input logic [35:0] d);
      for (int i = 0; i < 4; i++) if (!b[i]) mem[a][9*i+:9] = d[9*i+:9];
      nd = d;
      nv = 1'b1;
      chk("write drive", dqOe, 1'b0);
   endtask
   task automatic wr(input logic [16:0] a, input logic [3:0] b,
                     input logic [35:0] d);
      op(1'b0, 1'b0, b, 1'b0, a);
      put(a[5:0], b, d);
   endtask
   task automatic rd(input logic [16:0] a);
      op(1'b0, 1'b1, 4'hF, 1'b0, a);
      chk("read data", dqOut, mem[a[5:0]]);
      chk("read drive", dqOe, 1'b1);
   endtask

   task automatic t_lanes;
      chk("power-up drive", dqOe, 1'b0);
      wr(17'h05, 4'h0, 36'hF_0F0F_0F0F);
      rd(17'h05);
      for (int i = 0; i < 4; i++) begin
         wr(17'h05, ~(4'h1 << i), {4{9'h100 + 9'(i)}});
      end
      wr(17'h05, 4'hF, 36'h0_DEAD_BEEF);
      rd(17'h05);
      $display("test lanes done");
   endtask
   task automatic t_burst;
      logic [5:0] ex;
      for (int k = 0; k < 4; k++) wr(17'h20 + 17'(k), 4'h0, 36'h1_0000 + k);
      for (int o = 0; o < 2; o++) begin
         i_host.order = o[0];
         rd(17'h21);
         i_host.sel = 3'b110; // Selects off, ignored in continues
         for (int k = 1; k < 5; k++) begin
            ex = o ? 6'h20 | (6'h1 ^ 6'(k & 3)) : 6'h20 | 6'((1 + k) & 3);
            op(1'b1, 1'b0, 4'h0, k == 2, 17'h3F);
            if (k == 2) chk("dummy drive", dqOe, 1'b0);
            else chk("burst data", dqOut, mem[ex]);
         end
         i_host.sel = 3'b001;
      end
      wr(17'h28, 4'h0, 36'h2_2222_2222);
      op(1'b1, 1'b1, 4'h0, 1'b0, 17'h3F);
      put(6'h29, 4'h0, 36'h3_3333_3333);
      rd(17'h28);
      rd(17'h29);
      $display("test burst done");
   endtask
   task automatic t_stall;
      rd(17'h20);
      i_host.stall = 1'b1;
      op(1'b0, 1'b0, 4'h0, 1'b0, 17'h21);
      chk("stall data", dqOut, mem[6'h20]);
      chk("stall drive", dqOe, 1'b1);
      i_host.stall = 1'b0;
      op(1'b1, 1'b1, 4'hF, 1'b0, 17'h3F);
      chk("after stall", dqOut, mem[6'h21]);
      wr(17'h30, 4'h0, 36'hA_5A5A_5A5A);
      i_host.stall = 1'b1;
      op(1'b1, 1'b1, 4'hF, 1'b0, 17'h3F);
      chk("write stall drive", dqOe, 1'b0);
      i_host.stall = 1'b0;
      rd(17'h30);
      $display("test stall done");
   endtask
   task automatic t_desel;
      logic [2:0] offs [3] = '{3'b101, 3'b011, 3'b000};
      foreach (offs[i]) begin
         rd(17'h20);
         i_host.sel = offs[i];
         op(1'b0, 1'b1, 4'hF, 1'b0, 17'h20);
         chk("deselect drive", dqOe, 1'b0);
         i_host.sel = 3'b001;
         op(1'b1, 1'b1, 4'hF, 1'b0, 17'h20);
         chk("continue deselect", dqOe, 1'b0);
      end
      op(1'b0, 1'b1, 4'hF, 1'b1, 17'h20);
      chk("dummy read drive", dqOe, 1'b0);
      rd(17'h21);
      i_host.snooze = 1'b1;
      op(1'b0, 1'b0, 4'h0, 1'b0, 17'h21);
      chk("snooze drive", dqOe, 1'b0);
      i_host.snooze = 1'b0;
      rd(17'h21);
      $display("test deselect and snooze done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Reset, then the tests in turn
   initial begin
      mismatches = 0;
      testsRun = 0;
      nv = 1'b0;
      nd = '0;
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      t_lanes;
      t_burst;
      t_stall;
      t_desel;
      final_report;
   end
   // Tests need about 60 cycles; 2000 means a hang
   initial begin
      #(40 * 2000);
      mismatches++;
      final_report;
   end
endmodule
`default_nettype wire

// ---- verif/sync_sram_cycle_control_chk.sv ----
`default_nettype none
`include "sram_cycle_params.svh"
module sync_sram_cycle_control_chk
   import sram_cycle_pkg::*;
#(
   parameter int LANE_W = `LANE_WIDTH,
   parameter int LANES  = `LANE_COUNT
) (
   input wire logic                    clk,
   input wire logic                    rstn,
   input wire logic                    chipSelect_n,
   input wire logic                    expansion_select_n,
   input wire logic                    expansion_select,
   input wire logic                    snooze_request,
   input wire logic                    advance_or_load_n,
   input wire logic                    readNotWrite,
   input wire logic                    outputEnable_n,
   input wire logic                    clockEnable_n,
   input wire logic [LANES*LANE_W-1:0] dqOut,
   input wire logic                    dqOe
);
   timeunit 1ns;
   timeprecision 1ns;
   // Edge the device acts on
   wire taken = !clockEnable_n && !snooze_request;
   // All three selects active
   wire sel = !chipSelect_n && !expansion_select_n && expansion_select;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Begin cycles and continue cycles
   sequence rdBegin;
      taken && !advance_or_load_n && sel && readNotWrite;
   endsequence
   sequence wrBegin;
      taken && !advance_or_load_n && sel && !readNotWrite;
   endsequence
   sequence dsBegin;
      taken && !advance_or_load_n && !sel;
   endsequence
   sequence contTaken;
      taken && advance_or_load_n;
   endsequence
   chk_stall_hold: assert property (
      clockEnable_n && !snooze_request |=> $stable(dqOe) && $stable(dqOut))
      else $error("stall changed outputs");
   chk_write_off: assert property (wrBegin |=> !dqOe)
      else $error("driving in write");
   chk_desel_off: assert property (dsBegin |=> !dqOe)
      else $error("driving when deselected");
   chk_dummy_read: assert property (
      rdBegin ##0 outputEnable_n |=> !dqOe)
      else $error("driving in dummy read");
   chk_read_on: assert property (rdBegin ##0 !outputEnable_n |=> dqOe)
      else $error("read not driven");
   chk_cont_desel: assert property (dsBegin ##1 contTaken |=> !dqOe)
      else $error("continue deselect driven");
   chk_burst_read: assert property (
      rdBegin ##1 (contTaken ##0 !outputEnable_n) |=> dqOe)
      else $error("burst read not driven");
   chk_burst_write: assert property (wrBegin ##1 contTaken |=> !dqOe)
      else $error("burst write driven");
   chk_snooze_off: assert property (snooze_request |=> !dqOe)
      else $error("driving in snooze");
   chk_rise_cause: assert property (
      $rose(dqOe) |-> $past(taken && (advance_or_load_n || readNotWrite)))
      else $error("drivers on without read");
endmodule
bind sync_sram_cycle_control sync_sram_cycle_control_chk #(
   .LANE_W(LANE_W), .LANES(LANES)
) i_chk (
   .clk(clk), .rstn(rstn), .chipSelect_n(chipSelect_n),
   .expansion_select_n(expansion_select_n),
   .expansion_select(expansion_select), .snooze_request(snooze_request),
   .advance_or_load_n(advance_or_load_n), .readNotWrite(readNotWrite),
   .outputEnable_n(outputEnable_n), .clockEnable_n(clockEnable_n),
   .dqOut(dqOut), .dqOe(dqOe)
);
`default_nettype wire
